// ---- rtl/pending_clear_defs.svh ----
`ifndef PENDING_CLEAR_DEFS_SVH
`define PENDING_CLEAR_DEFS_SVH

// ----------------------------------------
// Register byte addresses
// ----------------------------------------
`define PC_GRP0_ADDR 32'he000_e280
`define PC_GRP1_ADDR 32'he000_e204
`define PC_EVT_STAT_ADDR 32'he000_e3f0
`define PC_EVT_CLR_ADDR 32'he000_e3f4
`define PC_EVT_EN_ADDR 32'he000_e3f8
`define PC_WORD_MASK 32'hffff_fffc

// ----------------------------------------
// Implemented bits and field edges
// ----------------------------------------
`define PC_GRP0_MASK 32'hffff_ffff
`define PC_GRP1_MASK 32'h03ef_ffff
`define PC_G1_WAKE_MASK 32'h0000_00ff
`define PC_G1_PERIPH_MASK 32'h000f_ff00
`define PC_G1_GPIO_MASK 32'h01e0_0000
`define PC_G1_SSP_MASK 32'h0200_0000
`define PC_PEND_RST 32'h0000_0000

// ----------------------------------------
// Event status layout
// ----------------------------------------
`define PC_EVT_W 3
`define PC_EVT_CLEARED 0
`define PC_EVT_RSVD 1
`define PC_EVT_BADADDR 2
`define PC_EVT_RST 3'h0

// ----------------------------------------
// Bus answers
// ----------------------------------------
`define PC_RESP_OKAY 2'h0
`define PC_RESP_SLVERR 2'h2
`define PC_DATA_ZERO 32'h0000_0000

`endif

// ---- rtl/pending_clear_pkg.sv ----
package pending_clear_pkg;

    typedef struct packed
    {
        logic [31:0] grp1;
        logic [31:0] grp0;
    } pend_pair_t;

    typedef enum logic [2:0]
    {
        SEL_NONE,
        SEL_GRP0,
        SEL_GRP1,
        SEL_EVT_STAT,
        SEL_EVT_CLR,
        SEL_EVT_EN
    } reg_sel_t;

endpackage

// ---- rtl/interrupt_pending_clear.sv ----
`timescale 1ns/1ps
`include "pending_clear_defs.svh"

module interrupt_pending_clear
    import pending_clear_pkg::*;
(
    input wire logic clock,
    input wire logic reset,
    input wire logic [31:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    input wire logic [31:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    input wire pend_pair_t irqLine,
    input wire pend_pair_t setPend,
    output pend_pair_t pending,
    output logic irq
);

    // ----------------------------------------
    // Decoding helpers
    // ----------------------------------------
    function automatic reg_sel_t regSel(input logic [31:0] addr);
        logic [31:0] word;
        word = addr & `PC_WORD_MASK;
        if (word == `PC_GRP0_ADDR)
            return SEL_GRP0;
        else if (word == `PC_GRP1_ADDR)
            return SEL_GRP1;
        else if (word == `PC_EVT_STAT_ADDR)
            return SEL_EVT_STAT;
        else if (word == `PC_EVT_CLR_ADDR)
            return SEL_EVT_CLR;
        else if (word == `PC_EVT_EN_ADDR)
            return SEL_EVT_EN;
        else
            return SEL_NONE;
    endfunction

    function automatic logic [31:0] laneMask(input logic [3:0] strb);
        logic [31:0] m;
        m = `PC_DATA_ZERO;
        for (int i = 0; i < 4; i++)
        begin
            m[i*8 +: 8] = {8{strb[i]}};
        end
        return m;
    endfunction

    // ----------------------------------------
    // Storage
    // ----------------------------------------
    logic awHeld_ff, wHeld_ff, bvalid_ff, awready_ff, wready_ff;
    logic [31:0] awAddr_ff, wData_ff;
    logic [3:0] wStrb_ff;
    logic [1:0] bresp_ff, rresp_ff;
    logic arready_ff, rvalid_ff;
    logic [31:0] rdata_ff;
    logic [31:0] pendG0_ff, pendG1_ff;
    logic [`PC_EVT_W-1:0] evtStat_ff, evtEn_ff;
    logic irq_ff;

    // ----------------------------------------
    // Write channel
    // ----------------------------------------
    logic awTake, wTake, wrFire, bTake;
    logic nxt_awHeld, nxt_wHeld, nxt_bvalid;
    reg_sel_t wrSel;
    logic [31:0] wrBits;

    assign awTake = awvalid & awready_ff;
    assign wTake = wvalid & wready_ff;
    assign bTake = bvalid_ff & bready;
    // Address and data may arrive in either order; act once both are held
    assign wrFire = awHeld_ff & wHeld_ff & ~bvalid_ff;
    assign nxt_awHeld = (awHeld_ff & ~wrFire) | awTake;
    assign nxt_wHeld = (wHeld_ff & ~wrFire) | wTake;
    assign nxt_bvalid = wrFire | (bvalid_ff & ~bTake);
    assign wrSel = regSel(awAddr_ff);
    assign wrBits = wData_ff & laneMask(wStrb_ff);

    always_ff @(posedge clock or posedge reset)
    begin
        if (reset)
        begin
            awHeld_ff <= 1'b0;
            wHeld_ff <= 1'b0;
            bvalid_ff <= 1'b0;
            awready_ff <= 1'b0;
            wready_ff <= 1'b0;
            bresp_ff <= `PC_RESP_OKAY;
        end
        else
        begin
            awHeld_ff <= nxt_awHeld;
            wHeld_ff <= nxt_wHeld;
            bvalid_ff <= nxt_bvalid;
            awready_ff <= ~nxt_awHeld & ~nxt_bvalid;
            wready_ff <= ~nxt_wHeld & ~nxt_bvalid;
            if (wrFire)
                bresp_ff <= (wrSel == SEL_NONE) ? `PC_RESP_SLVERR : `PC_RESP_OKAY;
        end
    end

    always_ff @(posedge clock)
    begin
        if (awTake)
            awAddr_ff <= awaddr;
        if (wTake)
        begin
            wData_ff <= wdata;
            wStrb_ff <= wstrb;
        end
    end

    // ----------------------------------------
    // Pending state
    // ----------------------------------------
    logic [31:0] clr0, clr1, set0, set1, keep0, keep1, nxt_pendG0, nxt_pendG1;

    // Only ones clear; zeros and disabled lanes leave state alone
    assign clr0 = (wrFire && wrSel == SEL_GRP0) ? wrBits : `PC_DATA_ZERO;
    assign clr1 = (wrFire && wrSel == SEL_GRP1) ? wrBits : `PC_DATA_ZERO;
    // Sources are level requests, so a live source stays pending through a clear
    assign set0 = (irqLine.grp0 | setPend.grp0) & `PC_GRP0_MASK;
    assign set1 = (irqLine.grp1 | setPend.grp1) & `PC_GRP1_MASK;
    assign keep0 = pendG0_ff & ~clr0;
    assign keep1 = pendG1_ff & ~clr1;
    // Set wins over a clear in the same cycle; reserved bits never hold state
    assign nxt_pendG0 = (keep0 | set0) & `PC_GRP0_MASK;
    assign nxt_pendG1 = (keep1 | set1) & `PC_GRP1_MASK;

    always_ff @(posedge clock or posedge reset)
    begin
        if (reset)
        begin
            pendG0_ff <= `PC_PEND_RST;
            pendG1_ff <= `PC_PEND_RST;
        end
        else
        begin
            pendG0_ff <= nxt_pendG0;
            pendG1_ff <= nxt_pendG1;
        end
    end

    assign pending = '{grp1: pendG1_ff, grp0: pendG0_ff};

    // ----------------------------------------
    // Event status and interrupt
    // ----------------------------------------
    logic [`PC_EVT_W-1:0] evtSet, evtClr, nxt_evtStat, nxt_evtEn;
    logic rdBad;

    assign evtSet[`PC_EVT_CLEARED] = |((pendG0_ff & clr0) | (pendG1_ff & clr1));
    // Software broke the reserved-bit convention; flagged, otherwise harmless
    assign evtSet[`PC_EVT_RSVD] = |(clr1 & ~`PC_GRP1_MASK);
    assign evtSet[`PC_EVT_BADADDR] = (wrFire && wrSel == SEL_NONE) | rdBad;
    assign evtClr = (wrFire && wrSel == SEL_EVT_CLR) ? wrBits[`PC_EVT_W-1:0] : `PC_EVT_RST;
    assign nxt_evtStat = (evtStat_ff & ~evtClr) | evtSet;
    assign nxt_evtEn = (wrFire && wrSel == SEL_EVT_EN) ? wrBits[`PC_EVT_W-1:0] : evtEn_ff;

    always_ff @(posedge clock or posedge reset)
    begin
        if (reset)
        begin
            evtStat_ff <= `PC_EVT_RST;
            evtEn_ff <= `PC_EVT_RST;
            irq_ff <= 1'b0;
        end
        else
        begin
            evtStat_ff <= nxt_evtStat;
            evtEn_ff <= nxt_evtEn;
            irq_ff <= |(nxt_evtStat & nxt_evtEn);
        end
    end

    // ----------------------------------------
    // Read channel
    // ----------------------------------------
    logic arTake, nxt_rvalid;
    reg_sel_t rdSel;
    logic [31:0] rdMux;

    assign arTake = arvalid & arready_ff;
    assign nxt_rvalid = arTake | (rvalid_ff & ~rready);
    assign rdSel = regSel(araddr);
    assign rdBad = arTake && rdSel == SEL_NONE;
    // Reserved bits read as zero since they hold no state
    assign rdMux =
        (rdSel == SEL_GRP0) ? pendG0_ff :
        (rdSel == SEL_GRP1) ? pendG1_ff :
        (rdSel == SEL_EVT_STAT) ? {29'h0000_0000, evtStat_ff} :
        (rdSel == SEL_EVT_EN) ? {29'h0000_0000, evtEn_ff} :
        `PC_DATA_ZERO;

    always_ff @(posedge clock or posedge reset)
    begin
        if (reset)
        begin
            arready_ff <= 1'b0;
            rvalid_ff <= 1'b0;
            rdata_ff <= `PC_DATA_ZERO;
            rresp_ff <= `PC_RESP_OKAY;
        end
        else
        begin
            arready_ff <= ~nxt_rvalid;
            rvalid_ff <= nxt_rvalid;
            if (arTake)
            begin
                rdata_ff <= rdMux;
                rresp_ff <= rdBad ? `PC_RESP_SLVERR : `PC_RESP_OKAY;
            end
        end
    end

    assign awready = awready_ff;
    assign wready = wready_ff;
    assign bvalid = bvalid_ff;
    assign bresp = bresp_ff;
    assign arready = arready_ff;
    assign rvalid = rvalid_ff;
    assign rdata = rdata_ff;
    assign rresp = rresp_ff;
    assign irq = irq_ff;

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    logic [31:0] clrOnly0, clrOnly1, setAny0, bothHit1;
    assign clrOnly0 = clr0 & ~set0;
    assign clrOnly1 = clr1 & ~set1;
    assign setAny0 = set0;
    assign bothHit1 = set1 & clr1;

    clear_one_a: assert property (@(posedge clock) disable iff (reset)
        wrFire |=> ((pendG0_ff & $past(clrOnly0)) == 0 && (pendG1_ff & $past(clrOnly1)) == 0))
        else $error("pending bit survived a clear write");

    zero_keeps_a: assert property (@(posedge clock) disable iff (reset)
        1'b1 |=> ((pendG0_ff & $past(keep0)) == $past(keep0)
            && (pendG1_ff & $past(keep1)) == $past(keep1)))
        else $error("pending bit lost without a clear");

    read_state_a: assert property (@(posedge clock) disable iff (reset)
        (arTake && rdSel == SEL_GRP0) |=> rvalid && rdata == $past(pendG0_ff)
            && rresp == `PC_RESP_OKAY)
        else $error("read of first register wrong");

    wake_group0_a: assert property (@(posedge clock) disable iff (reset)
        1'b1 |=> ((pendG0_ff & $past(setAny0)) == $past(setAny0)))
        else $error("wake pin request not pended");

    wake_group1_a: assert property (@(posedge clock) disable iff (reset)
        (irqLine.grp1 & `PC_G1_WAKE_MASK) != 0
            |=> (pendG1_ff & `PC_G1_WAKE_MASK) != 0)
        else $error("second group wake pin not pended");

    periph_bits_a: assert property (@(posedge clock) disable iff (reset)
        (setPend.grp1 & `PC_G1_PERIPH_MASK) != 0
            |=> (pendG1_ff & `PC_G1_PERIPH_MASK) != 0)
        else $error("peripheral request not pended");

    gpio_ssp_a: assert property (@(posedge clock) disable iff (reset)
        (irqLine.grp1 & (`PC_G1_GPIO_MASK | `PC_G1_SSP_MASK)) != 0
            |=> (pendG1_ff & (`PC_G1_GPIO_MASK | `PC_G1_SSP_MASK)) != 0)
        else $error("port or serial request not pended");

    reserved_zero_a: assert property (@(posedge clock) disable iff (reset)
        (pendG1_ff & ~`PC_GRP1_MASK) == 0)
        else $error("reserved pending bit holds state");

    reserved_read_a: assert property (@(posedge clock) disable iff (reset)
        (arTake && rdSel == SEL_GRP1) |=> (rdata & ~`PC_GRP1_MASK) == 0)
        else $error("reserved bit read back as one");

    no_soft_set_a: assert property (@(posedge clock) disable iff (reset)
        ((irqLine.grp0 | setPend.grp0) == 0) |=> (pendG0_ff & ~$past(pendG0_ff)) == 0)
        else $error("pending rose without a set request");

    group1_decode_a: assert property (@(posedge clock) disable iff (reset)
        (arTake && (araddr & `PC_WORD_MASK) == `PC_GRP1_ADDR)
            |=> rdata == $past(pendG1_ff) && rresp == `PC_RESP_OKAY)
        else $error("second register not decoded");

    irq_level_a: assert property (@(posedge clock) disable iff (reset)
        irq == |(evtStat_ff & evtEn_ff))
        else $error("interrupt does not follow enabled status");

    write_resp_a: assert property (@(posedge clock) disable iff (reset)
        wrFire |=> bvalid)
        else $error("write response missing");

    // Channels stay shut while an answer waits, so no second access overlaps it
    busy_closed_a: assert property (@(posedge clock) disable iff (reset)
        bvalid |-> !awready && !wready)
        else $error("write channel open during response");

    read_closed_a: assert property (@(posedge clock) disable iff (reset)
        rvalid |-> !arready)
        else $error("read channel open during response");

    bad_write_a: assert property (@(posedge clock) disable iff (reset)
        (wrFire && wrSel == SEL_NONE) |=> bvalid && bresp == `PC_RESP_SLVERR)
        else $error("unmapped write not refused");

    bad_read_a: assert property (@(posedge clock) disable iff (reset)
        rdBad |=> rvalid && rresp == `PC_RESP_SLVERR && rdata == `PC_DATA_ZERO)
        else $error("unmapped read not refused");

    evt_sticky_a: assert property (@(posedge clock) disable iff (reset)
        (evtSet != 0) |=> (evtStat_ff & $past(evtSet)) == $past(evtSet))
        else $error("event status lost a new event");

    set_wins_a: assert property (@(posedge clock) disable iff (reset)
        (bothHit1 != 0) |=> (pendG1_ff & $past(bothHit1)) == $past(bothHit1))
        else $error("clear beat a live request");

endmodule

// ---- verif/irq_source_model.sv ----
`timescale 1ns/1ps
`include "pending_clear_defs.svh"
module irq_source_model
    import pending_clear_pkg::*;
(
    input wire pend_pair_t pulseReq,
    input wire pend_pair_t levelReq,
    output pend_pair_t irqLine,
    output pend_pair_t setPend
);
    // ----------------------------------------
    // Peripheral sources
    // ----------------------------------------
    // Sources exist only at implemented positions, so reserved grp1 bits stay quiet
    pend_pair_t keep;
    assign keep = {`PC_GRP1_MASK, `PC_GRP0_MASK};
    assign irqLine = levelReq & keep;
    assign setPend = pulseReq & keep;
endmodule

// ---- verif/tb.sv ----
`timescale 1ns/1ps
`include "pending_clear_defs.svh"
module tb;
    import pending_clear_pkg::*;
    logic clock = 1'b0;
    logic reset = 1'b1;
    logic [31:0] awaddr = '0, wdata = '0, araddr = '0, rdata;
    logic [3:0] wstrb = 4'hf;
    logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
    logic awready, wready, bvalid, arready, rvalid, irq;
    logic [1:0] bresp, rresp;
    pend_pair_t pulseReq = '0, levelReq = '0, irqLine, setPend, pending, expPend;
    int fail_count = 0;
    int compares = 0;
    always #2.5 clock = ~clock;
    irq_source_model src (.pulseReq(pulseReq), .levelReq(levelReq), .irqLine(irqLine),
        .setPend(setPend));
    interrupt_pending_clear dut (.clock(clock), .reset(reset), .awaddr(awaddr),
        .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
        .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
        .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
        .rready(rready), .irqLine(irqLine), .setPend(setPend), .pending(pending), .irq(irq));
    // ----------------------------------------
    // Bus master and compare
    // ----------------------------------------
    task automatic chk(input string name, input logic [63:0] exp, input logic [63:0] got);
        compares++;
        if (got !== exp)
        begin
            fail_count++;
            $display("[ERR] %s expected %h seen %h", name, exp, got);
        end
    endtask
    // Waits as long as it takes; only the watchdog ends a hung access
    task automatic bus_write(input logic [31:0] a, input logic [31:0] d, output logic [1:0] r);
        @(posedge clock);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do
        begin
            @(posedge clock);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
        end
        while (bvalid !== 1'b1);
        r = bresp;
        bready <= 1'b0;
    endtask
    task automatic bus_read(input logic [31:0] a, output logic [31:0] d, output logic [1:0] r);
        @(posedge clock);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do
        begin
            @(posedge clock);
            if (arvalid && arready) arvalid <= 1'b0;
        end
        while (rvalid !== 1'b1);
        d = rdata;
        r = rresp;
        rready <= 1'b0;
    endtask
    // Write one register, then check the vector at the port and through both read-backs
    task automatic clear_and_check(input logic [31:0] a, input logic [31:0] d);
        logic [1:0] r;
        logic [31:0] v;
        bus_write(a, d, r);
        chk("bresp", `PC_RESP_OKAY, r);
        chk("pending", expPend, pending);
        bus_read(`PC_GRP0_ADDR, v, r);
        chk("grp0 read", expPend.grp0, v);
        chk("grp0 rresp", `PC_RESP_OKAY, r);
        bus_read(`PC_GRP1_ADDR, v, r);
        chk("grp1 read", expPend.grp1 & `PC_GRP1_MASK, v & `PC_GRP1_MASK);
    endtask
    task automatic fire_all();
        @(posedge clock);
        pulseReq <= {`PC_GRP1_MASK, `PC_GRP0_MASK};
        @(posedge clock);
        pulseReq <= '0;
        repeat (2) @(posedge clock);
        expPend = {`PC_GRP1_MASK, `PC_GRP0_MASK};
    endtask
    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic scen_reset();
        chk("pending rst", '0, pending);
        chk("irq rst", '0, irq);
    endtask
    task automatic scen_grp0();
        fire_all();
        clear_and_check(`PC_GRP0_ADDR, 32'h0000_0000);
        expPend.grp0 = 32'h7fff_fffe;
        clear_and_check(`PC_GRP0_ADDR, 32'h8000_0001);
        expPend.grp0 = 32'h2aaa_5554;
        clear_and_check(`PC_GRP0_ADDR, 32'h5555_aaaa);
    endtask
    task automatic scen_grp1();
        logic [31:0] fields [4];
        fields = '{`PC_G1_WAKE_MASK, `PC_G1_PERIPH_MASK, `PC_G1_GPIO_MASK, `PC_G1_SSP_MASK};
        fire_all();
        foreach (fields[i])
        begin
            expPend.grp1 = expPend.grp1 & ~fields[i];
            clear_and_check(`PC_GRP1_ADDR, fields[i]);
        end
        chk("grp0 kept", `PC_GRP0_MASK, pending.grp0);
    endtask
    task automatic scen_no_set();
        expPend = '0;
        clear_and_check(`PC_GRP0_ADDR, 32'hffff_ffff);
        clear_and_check(`PC_GRP1_ADDR, `PC_GRP1_MASK);
        clear_and_check(`PC_GRP1_ADDR, 32'h0000_0000);
    endtask
    // Live level sources re-pend through a clear; a dropped one stays cleared
    task automatic scen_level();
        logic [31:0] live;
        live = `PC_G1_WAKE_MASK | `PC_G1_GPIO_MASK | `PC_G1_SSP_MASK;
        @(posedge clock);
        levelReq <= {live, 32'h0000_0000};
        repeat (2) @(posedge clock);
        expPend = {live, 32'h0000_0000};
        clear_and_check(`PC_GRP1_ADDR, live);
        levelReq <= '0;
        @(posedge clock);
        expPend = '0;
        clear_and_check(`PC_GRP1_ADDR, live);
    endtask
    task automatic scen_reset_mid();
        logic [1:0] r;
        logic [31:0] v;
        fire_all();
        bus_read(32'he000_e100, v, r);
        chk("irq pre rst", 1, irq);
        reset <= 1'b1;
        repeat (3) @(posedge clock);
        reset <= 1'b0;
        repeat (2) @(posedge clock);
        expPend = '0;
        chk("pending mid rst", expPend, pending);
        chk("irq mid rst", '0, irq);
        clear_and_check(`PC_GRP0_ADDR, 32'h0000_0000);
    endtask
    task automatic scen_events();
        logic [1:0] r;
        logic [31:0] v;
        bus_read(`PC_EVT_STAT_ADDR, v, r);
        chk("evt clear seen", 32'h0000_0001, v);
        bus_write(`PC_EVT_CLR_ADDR, 32'h0000_0007, r);
        bus_write(`PC_EVT_EN_ADDR, 32'h0000_0006, r);
        bus_write(`PC_GRP1_ADDR, 32'h0010_0000, r);
        bus_read(`PC_EVT_STAT_ADDR, v, r);
        chk("evt reserved", 32'h0000_0002, v);
        chk("irq on", 1, irq);
        bus_read(32'he000_e100, v, r);
        chk("unmapped resp", `PC_RESP_SLVERR, r);
        chk("unmapped data", `PC_DATA_ZERO, v);
        bus_write(32'he000_e104, 32'h0000_0000, r);
        chk("unmapped wresp", `PC_RESP_SLVERR, r);
        bus_write(`PC_EVT_EN_ADDR, 32'h0000_0000, r);
        bus_read(`PC_EVT_STAT_ADDR, v, r);
        chk("evt both", 32'h0000_0006, v);
        chk("irq masked", 0, irq);
        bus_write(`PC_EVT_EN_ADDR, 32'h0000_0006, r);
        bus_write(`PC_EVT_CLR_ADDR, 32'h0000_0006, r);
        bus_read(`PC_EVT_STAT_ADDR, v, r);
        chk("evt cleared", 32'h0000_0000, v);
        chk("irq off", 0, irq);
    endtask
    // ----------------------------------------
    // Run control
    // ----------------------------------------
    task automatic test_done();
        $display("compares %0d fail_count %0d", compares, fail_count);
        if (fail_count == 0 && compares > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    initial
    begin
        repeat (12) @(posedge clock);
        reset <= 1'b0;
        repeat (2) @(posedge clock);
        scen_reset();
        scen_grp0();
        scen_grp1();
        scen_no_set();
        scen_level();
        scen_events();
        scen_reset_mid();
        test_done();
    end
    initial
    begin
        repeat (5000) @(posedge clock);
        fail_count++;
        test_done();
    end
endmodule
